// >>> verilog/backlight_map.svh
// Purpose: Address, field and timing names for the backlight control and status registers.
// Assumes: 8-bit registers on an 8-bit register address space, clk_sys at 20 MHz.
// Notes: Definitions only.
//
// Functional notes
// R1 - With the fast bit (control bit 7) at 0, trim data is reloaded on every exit from standby, at 1 only at power-up.
// R2 - Source field bits 2:1 at 00b takes brightness from the pulse-width input alone.
// R3 - Source field at 10b takes brightness only from the brightness register and ignores the pulse-width input.
// R4 - Source field at 01b merges pulse-width input and brightness register ahead of the shaper.
// R5 - Source field at 11b merges pulse-width input and brightness register after the shaper.
// R6 - In register-only mode, control bit 0 at 0 turns backlight and chip off, at 1 turns them on.
// R7 - In any pulse-width mode, activity on the pulse-width pin enables or disables the chip instead of bit 0.
// R8 - Status bit 7 follows the live LED open condition without latching.
// R9 - Status bit 6 follows the live LED short condition without latching.
// R10 - Status bit 4 shows live whether the boost output has reached its target.
// R11 - Overvoltage, overcurrent and thermal fault bits latch at 1 and clear when status is read.
// R12 - Writes to the status register change nothing, and unassigned control bits read as zero.
`ifndef BACKLIGHT_MAP_SVH
`define BACKLIGHT_MAP_SVH

// ----------------------------------------------------------------------
// Register addresses and reset values
// ----------------------------------------------------------------------
`define ADDR_DEVICE_CONTROL 8'h01
`define ADDR_FAULT_STATUS 8'h02
`define RESET_DEVICE_CONTROL 8'h00
`define RESET_FAULT_STATUS 8'h00
`define READ_UNMAPPED 8'h00

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTL_FAST_BIT 7
`define CTL_SOURCE_HI 2
`define CTL_SOURCE_LO 1
`define CTL_SOFT_ENABLE_BIT 0
`define CTL_WRITABLE_MASK 8'h87

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define STS_OPEN_BIT 7
`define STS_SHORT_BIT 6
`define STS_VREF_BIT 5
`define STS_BOOST_BIT 4
`define STS_LATCH_HI 3
`define STS_LATCH_LO 0
`define STS_LATCH_WIDTH 4

// ----------------------------------------------------------------------
// Timing and datapath constants
// ----------------------------------------------------------------------
`define CLK_SYS_FREQ_HZ 20000000
`define PWM_IDLE_TIME_US 100
`define PWM_IDLE_CYCLES ((`PWM_IDLE_TIME_US * (`CLK_SYS_FREQ_HZ / 1000000)))
`define PWM_IDLE_CNT_WIDTH 12
`define GAIN_UNITY 8'hff

`endif

// >>> verilog/backlight_pkg.sv
// Purpose: Types shared by the backlight control and status register logic.
// Assumes: Nothing beyond the register map header.
// Notes: Encodings of the brightness source field and the power sequencer states.
package backlight_pkg;

   typedef enum logic [1:0] {
      SRC_PWM_ONLY   = 2'b00,
      SRC_MERGE_PRE  = 2'b01,
      SRC_REG_ONLY   = 2'b10,
      SRC_MERGE_POST = 2'b11
   } brightness_source_e;

   typedef enum logic [3:0] {
      ST_LOAD    = 4'b0001,
      ST_ACTIVE  = 4'b0010,
      ST_STANDBY = 4'b0100,
      ST_WAKE    = 4'b1000
   } power_state_e;

endpackage : backlight_pkg

// >>> verilog/fault_status_if.sv
// Purpose: Carries latched fault events and their read clear between modules.
// Assumes: One clock domain.
// Notes: The register side sets clear, the latch side returns the held flags.
`timescale 1ns/10ps
`include "backlight_map.svh"

interface fault_status_if;
   logic [`STS_LATCH_WIDTH-1:0] faultEvent;
   logic readClear;
   logic [`STS_LATCH_WIDTH-1:0] faultHeld;

   modport regs (output faultEvent, output readClear, input faultHeld);
   modport latch (input faultEvent, input readClear, output faultHeld);
endinterface : fault_status_if

// >>> verilog/fault_status_latch.sv
// Purpose: Sticky fault flags that clear when the status register is read.
// Assumes: Events are synchronous to clk_sys.
// Notes: An event in the cycle of the clearing read keeps its flag set.
`timescale 1ns/10ps
`include "backlight_map.svh"

module fault_status_latch (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clkEn,
   fault_status_if.latch flags
);

   logic [`STS_LATCH_WIDTH-1:0] held_reg;

   // ----------------------------------------------------------------------
   // Sticky flags
   // ----------------------------------------------------------------------
   // Set has priority over the read clear so no event is lost.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         held_reg <= `STS_LATCH_WIDTH'(`RESET_FAULT_STATUS);
      end else if (clkEn) begin
         if (flags.readClear) begin
            held_reg <= flags.faultEvent; // see R11
         end else begin
            held_reg <= held_reg | flags.faultEvent; // see R11
         end
      end
   end

   assign flags.faultHeld = held_reg;

endmodule : fault_status_latch

// >>> verilog/backlight_control_status_regs.sv
// Purpose: Device control and fault status registers of a backlight driver.
// Assumes: The serial slave presents one-cycle read and write strobes with an address.
// Notes: Drives brightness source steering, chip enable and the trim reload sequence.
`timescale 1ns/10ps
`include "backlight_map.svh"

module backlight_control_status_regs
   import backlight_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWriteData,
   input wire logic regRead,
   output logic [7:0] regReadData,
   output logic regReadValid,
   input wire logic pwmIn,
   input wire logic [7:0] pwmDuty,
   input wire logic [7:0] brightnessLevel,
   input wire logic ledOpenDetect,
   input wire logic ledShortDetect,
   input wire logic vrefOkDetect,
   input wire logic boostTargetReached,
   input wire logic overvoltageEvent,
   input wire logic overcurrentEvent,
   input wire logic thermalEvent,
   input wire logic supplyLowEvent,
   input wire logic trimLoadDone,
   output logic [7:0] shaperInput,
   output logic [7:0] postShaperGain,
   output logic chipEnable,
   output logic trimLoadStart,
   output logic deviceActive
);

   logic [7:0] deviceControl_reg;
   logic [7:0] deviceControl_next;
   logic [7:0] faultStatus;
   logic [7:0] readData_reg;
   logic readValid_reg;
   logic ctlHit;
   logic stsHit;
   logic fastWake;
   logic softEnable;
   brightness_source_e sourceSel;
   logic pwmPrev_reg;
   logic pwmActive_reg;
   logic [`PWM_IDLE_CNT_WIDTH-1:0] pwmIdleCnt_reg;
   logic enableWanted;
   logic chipEnable_reg;
   logic [15:0] mergeProduct;
   logic [7:0] shaperInput_reg;
   logic [7:0] postGain_reg;
   power_state_e state_reg;
   power_state_e state_next;
   logic trimStart_reg;

   fault_status_if flags ();

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   always_comb begin
      ctlHit = 1'b0;
      stsHit = 1'b0;
      if (regAddr == `ADDR_DEVICE_CONTROL) begin
         ctlHit = 1'b1;
      end else if (regAddr == `ADDR_FAULT_STATUS) begin
         stsHit = 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Device control register
   // ----------------------------------------------------------------------
   // Only the fast, source and soft enable bits are stored; the rest read zero.
   assign deviceControl_next = regWriteData & `CTL_WRITABLE_MASK; // see R12

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         deviceControl_reg <= `RESET_DEVICE_CONTROL;
      end else if (clkEn && regWrite && ctlHit) begin
         deviceControl_reg <= deviceControl_next;
      end
   end

   assign fastWake = deviceControl_reg[`CTL_FAST_BIT];
   assign softEnable = deviceControl_reg[`CTL_SOFT_ENABLE_BIT];
   assign sourceSel = brightness_source_e'(deviceControl_reg[`CTL_SOURCE_HI:`CTL_SOURCE_LO]);

   // ----------------------------------------------------------------------
   // Fault status register
   // ----------------------------------------------------------------------
   // Writes to the status address are not decoded, so they change nothing.
   assign flags.faultEvent = {overvoltageEvent, overcurrentEvent, thermalEvent, supplyLowEvent};
   assign flags.readClear = regRead && stsHit; // see R11
   assign faultStatus[`STS_OPEN_BIT] = ledOpenDetect; // see R8
   assign faultStatus[`STS_SHORT_BIT] = ledShortDetect; // see R9
   assign faultStatus[`STS_VREF_BIT] = vrefOkDetect;
   assign faultStatus[`STS_BOOST_BIT] = boostTargetReached; // see R10
   assign faultStatus[`STS_LATCH_HI:`STS_LATCH_LO] = flags.faultHeld; // see R11 R12

   fault_status_latch u_fault_latch (
      .clk_sys(clk_sys),
      .rst(rst),
      .clkEn(clkEn),
      .flags(flags.latch)
   );

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         readData_reg <= `READ_UNMAPPED;
         readValid_reg <= 1'b0;
      end else if (clkEn) begin
         readValid_reg <= regRead;
         if (regRead) begin
            if (ctlHit) begin
               readData_reg <= deviceControl_reg; // see R12
            end else if (stsHit) begin
               readData_reg <= faultStatus;
            end else begin
               readData_reg <= `READ_UNMAPPED;
            end
         end
      end
   end

   assign regReadData = readData_reg;
   assign regReadValid = readValid_reg;

   // ----------------------------------------------------------------------
   // Pulse-width input activity
   // ----------------------------------------------------------------------
   // The input counts as active while it is high or has toggled within the idle window.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pwmPrev_reg <= 1'b0;
         pwmIdleCnt_reg <= '0;
         pwmActive_reg <= 1'b0;
      end else if (clkEn) begin
         pwmPrev_reg <= pwmIn;
         if (pwmIn || (pwmIn != pwmPrev_reg)) begin
            pwmIdleCnt_reg <= '0;
            pwmActive_reg <= 1'b1;
         end else if (pwmIdleCnt_reg == `PWM_IDLE_CNT_WIDTH'(`PWM_IDLE_CYCLES - 1)) begin
            pwmActive_reg <= 1'b0;
         end else begin
            pwmIdleCnt_reg <= pwmIdleCnt_reg + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Chip enable
   // ----------------------------------------------------------------------
   always_comb begin
      if (sourceSel == SRC_REG_ONLY) begin
         enableWanted = softEnable; // see R6
      end else begin
         enableWanted = pwmActive_reg; // see R7
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         chipEnable_reg <= 1'b0;
      end else if (clkEn) begin
         chipEnable_reg <= enableWanted;
      end
   end

   assign chipEnable = chipEnable_reg;

   // ----------------------------------------------------------------------
   // Brightness source steering
   // ----------------------------------------------------------------------
   // The merge scales the duty by the register level, full scale being unity.
   assign mergeProduct = pwmDuty * brightnessLevel;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         shaperInput_reg <= 8'h00;
         postGain_reg <= `GAIN_UNITY;
      end else if (clkEn) begin
         case (sourceSel)
            SRC_PWM_ONLY: begin
               shaperInput_reg <= pwmDuty; // see R2
               postGain_reg <= `GAIN_UNITY;
            end
            SRC_MERGE_PRE: begin
               shaperInput_reg <= mergeProduct[15:8]; // see R4
               postGain_reg <= `GAIN_UNITY;
            end
            SRC_REG_ONLY: begin
               shaperInput_reg <= brightnessLevel; // see R3
               postGain_reg <= `GAIN_UNITY;
            end
            default: begin
               shaperInput_reg <= pwmDuty; // see R5
               postGain_reg <= brightnessLevel; // see R5
            end
         endcase
      end
   end

   assign shaperInput = shaperInput_reg;
   assign postShaperGain = postGain_reg;

   // ----------------------------------------------------------------------
   // Power sequencer
   // ----------------------------------------------------------------------
   // Reset is the initial power-up, so trim is always loaded once first.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_LOAD: begin
            if (trimLoadDone) begin
               state_next = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (!chipEnable_reg) begin
               state_next = ST_STANDBY;
            end
         end
         ST_STANDBY: begin
            if (chipEnable_reg && fastWake) begin
               state_next = ST_ACTIVE; // see R1
            end else if (chipEnable_reg) begin
               state_next = ST_WAKE; // see R1
            end
         end
         ST_WAKE: begin
            if (trimLoadDone) begin
               state_next = ST_ACTIVE;
            end
         end
         default: begin
            state_next = ST_LOAD;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg <= ST_LOAD;
      end else if (clkEn) begin
         state_reg <= state_next;
      end
   end

   // The load request is one pulse on entry to a loading state.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         trimStart_reg <= 1'b1;
      end else if (clkEn) begin
         trimStart_reg <= (state_reg == ST_STANDBY) && (state_next == ST_WAKE); // see R1
      end
   end

   assign trimLoadStart = trimStart_reg;
   assign deviceActive = (state_reg == ST_ACTIVE);

endmodule : backlight_control_status_regs

// >>> sim/backlight_regs_sva.sv
// Purpose: Port assertions for the backlight control and status registers.
// Assumes: One clock, rst asynchronous active high.
// Notes: The control register is shadowed from the writes seen at the ports.
`timescale 1ns/10ps
module backlight_regs_sva (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWriteData,
   input wire logic regRead,
   input wire logic [7:0] regReadData,
   input wire logic regReadValid,
   input wire logic [7:0] pwmDuty,
   input wire logic [7:0] brightnessLevel,
   input wire logic ledOpenDetect,
   input wire logic ledShortDetect,
   input wire logic vrefOkDetect,
   input wire logic boostTargetReached,
   input wire logic overvoltageEvent,
   input wire logic overcurrentEvent,
   input wire logic thermalEvent,
   input wire logic supplyLowEvent,
   input wire logic [7:0] shaperInput,
   input wire logic [7:0] postShaperGain,
   input wire logic chipEnable,
   input wire logic trimLoadStart
);
   logic [7:0] ctlShadow_reg;
   logic [15:0] mergeProd;
   logic [3:0] events;
   logic [3:0] liveBits;
   logic [7:0] mergeHi;
   logic softShadow;
   assign mergeProd = pwmDuty * brightnessLevel;
   assign events = {overvoltageEvent, overcurrentEvent, thermalEvent, supplyLowEvent};
   assign liveBits = {ledOpenDetect, ledShortDetect, vrefOkDetect, boostTargetReached};
   assign mergeHi = mergeProd[15:8];
   assign softShadow = ctlShadow_reg[0];
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctlShadow_reg <= 8'h00;
      end else if (clkEn && regWrite && regAddr == 8'h01) begin
         ctlShadow_reg <= regWriteData & 8'h87;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_stsRead;
      clkEn && regRead && regAddr == 8'h02 && events == 4'h0;
   endsequence
   property p_liveStatus;
      clkEn && regRead && regAddr == 8'h02 |=> regReadValid &&
         regReadData[7:4] == $past(liveBits);
   endproperty
   a_liveStatus: assert property (p_liveStatus) else $error("live status bits wrong");
   property p_ctlRead;
      clkEn && regRead && regAddr == 8'h01 |=> regReadData == $past(ctlShadow_reg);
   endproperty
   a_ctlRead: assert property (p_ctlRead) else $error("control readback wrong");
   property p_unmapped;
      clkEn && regRead && regAddr != 8'h01 && regAddr != 8'h02 |=> regReadData == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_stickyClear;
      s_stsRead ##1 events == 4'h0 ##1 s_stsRead |=> regReadData[3:0] == 4'h0;
   endproperty
   a_stickyClear: assert property (p_stickyClear) else $error("fault not cleared");
   property p_srcPwm;
      clkEn && ctlShadow_reg[2:1] == 2'b00 |=> shaperInput == $past(pwmDuty) &&
         postShaperGain == 8'hff;
   endproperty
   a_srcPwm: assert property (p_srcPwm) else $error("pulse width source wrong");
   property p_srcMergePre;
      clkEn && ctlShadow_reg[2:1] == 2'b01 |=> shaperInput == $past(mergeHi);
   endproperty
   a_srcMergePre: assert property (p_srcMergePre) else $error("pre merge wrong");
   property p_srcReg;
      clkEn && ctlShadow_reg[2:1] == 2'b10 |=> shaperInput == $past(brightnessLevel);
   endproperty
   a_srcReg: assert property (p_srcReg) else $error("register source wrong");
   property p_srcMergePost;
      clkEn && ctlShadow_reg[2:1] == 2'b11 |=> shaperInput == $past(pwmDuty) &&
         postShaperGain == $past(brightnessLevel);
   endproperty
   a_srcMergePost: assert property (p_srcMergePost) else $error("post merge wrong");
   property p_softEnable;
      clkEn && ctlShadow_reg[2:1] == 2'b10 |=> chipEnable == $past(softShadow);
   endproperty
   a_softEnable: assert property (p_softEnable) else $error("soft enable ignored");
   property p_noReload;
      clkEn && ctlShadow_reg[7] && !trimLoadStart |=> !trimLoadStart;
   endproperty
   a_noReload: assert property (p_noReload) else $error("reload with fast bit set");
   property p_reloadPulse;
      clkEn && $rose(trimLoadStart) |=> !trimLoadStart;
   endproperty
   a_reloadPulse: assert property (p_reloadPulse) else $error("reload pulse too long");
endmodule : backlight_regs_sva

bind backlight_control_status_regs backlight_regs_sva backlight_regs_sva_inst (
   .clk_sys, .rst, .clkEn, .regAddr, .regWrite, .regWriteData, .regRead, .regReadData,
   .regReadValid, .pwmDuty, .brightnessLevel, .ledOpenDetect, .ledShortDetect, .vrefOkDetect,
   .boostTargetReached, .overvoltageEvent, .overcurrentEvent, .thermalEvent, .supplyLowEvent,
   .shaperInput, .postShaperGain, .chipEnable, .trimLoadStart
);

// >>> sim/serial_host_model.sv
// Purpose: Host side of the serial register link, as single byte strobes.
// Assumes: Signals change 2 ns after the rising edge of clk_sys.
// Notes: Released address and data show the inverse of the last value.
`timescale 1ns/10ps
module serial_host_model (
   input wire logic clk_sys,
   output logic [7:0] regAddr,
   output logic regWrite,
   output logic [7:0] regWriteData,
   output logic regRead,
   input wire logic [7:0] regReadData,
   input wire logic regReadValid
);
   initial begin
      regAddr = 8'h00;
      regWrite = 1'b0;
      regWriteData = 8'h00;
      regRead = 1'b0;
   end
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, input int gap);
      repeat (gap + 1) @(posedge clk_sys);
      #2;
      regAddr = addr;
      regWriteData = data;
      regWrite = 1'b1;
      @(posedge clk_sys);
      #2;
      regWrite = 1'b0;
      regAddr = ~addr;
      regWriteData = ~data;
   endtask : write_reg
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clk_sys);
      #2;
      regAddr = addr;
      regRead = 1'b1;
      @(posedge clk_sys);
      #2;
      regRead = 1'b0;
      regAddr = ~addr;
      data = (regReadValid === 1'b1) ? regReadData : 8'hxx;
   endtask : read_reg
endmodule : serial_host_model

// >>> sim/backlight_control_status_regs_tb.sv
// Purpose: Self-checking bench for the backlight control and status registers.
// Assumes: Seeded random stimulus, host strobes from the host model.
// Notes: Pulse-width idle timeout runs at its full 2000 cycles.
`timescale 1ns/10ps
module backlight_control_status_regs_tb;
   logic clk_sys, rst, clkEn, pwmIn, trimLoadDone, regWrite, regRead, regReadValid;
   logic chipEnable, trimLoadStart, deviceActive;
   logic [7:0] regAddr, regWriteData, regReadData, pwmDuty, brightnessLevel, shaperInput;
   logic [7:0] postShaperGain, rd, wv;
   logic [3:0] live, evt;
   int badCount, nTests, cycles, reloadCount, loads;
   backlight_control_status_regs backlight_control_status_regs_inst (
      .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .regAddr(regAddr), .regWrite(regWrite),
      .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData),
      .regReadValid(regReadValid), .pwmIn(pwmIn), .pwmDuty(pwmDuty),
      .brightnessLevel(brightnessLevel), .ledOpenDetect(live[3]), .ledShortDetect(live[2]),
      .vrefOkDetect(live[1]), .boostTargetReached(live[0]), .overvoltageEvent(evt[3]),
      .overcurrentEvent(evt[2]), .thermalEvent(evt[1]), .supplyLowEvent(evt[0]),
      .trimLoadDone(trimLoadDone), .shaperInput(shaperInput), .postShaperGain(postShaperGain),
      .chipEnable(chipEnable), .trimLoadStart(trimLoadStart), .deviceActive(deviceActive));
   serial_host_model serial_host_model_inst (.clk_sys(clk_sys), .regAddr(regAddr),
      .regWrite(regWrite), .regWriteData(regWriteData), .regRead(regRead),
      .regReadData(regReadData), .regReadValid(regReadValid));
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (!rst && trimLoadStart === 1'b1) reloadCount++;
      if (cycles == 20000) begin
         badCount++;
         stopTest();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      nTests++;
      if (seen !== exp) begin
         badCount++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [7:0] exp_shaper(input logic [1:0] m, input logic [7:0] d,
                                             input logic [7:0] l);
      logic [15:0] p;
      p = {8'h00, d} * {8'h00, l};
      return (m == 2'b01) ? p[15:8] : (m == 2'b10) ? l : d;
   endfunction : exp_shaper
   task automatic stopTest;
      $display("Counts: %0d checks, %0d mismatches", nTests, badCount);
      if (badCount == 0 && nTests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stopTest
   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      clkEn = 1'b1;
      pwmIn = 1'b1;
      pwmDuty = 8'h00;
      brightnessLevel = 8'h00;
      live = 4'h0;
      evt = 4'h0;
      trimLoadDone = 1'b1;
      void'($urandom(53135));
      repeat (16) @(posedge clk_sys);
      #2;
      rst = 1'b0;
      serial_host_model_inst.read_reg(8'h01, rd);
      check(rd, 8'h00);
      for (int i = 0; i < 12; i++) begin
         wv = 8'($urandom);
         wv[2:1] = i[1:0];
         pwmDuty = (i < 4) ? 8'hff : 8'($urandom);
         brightnessLevel = 8'($urandom);
         serial_host_model_inst.write_reg(8'h01, wv, i % 3);
         serial_host_model_inst.read_reg(8'h01, rd);
         check(rd, wv & 8'h87);
         check(shaperInput, exp_shaper(wv[2:1], pwmDuty, brightnessLevel));
         check(postShaperGain, (wv[2:1] == 2'b11) ? brightnessLevel : 8'hff);
         check({7'h00, chipEnable}, {7'h00, wv[2:1] != 2'b10 || wv[0]});
      end
      $display("Test steering done");
      for (int i = 0; i < 6; i++) begin
         live = 4'($urandom);
         serial_host_model_inst.write_reg(8'h02, 8'hff, 0);
         serial_host_model_inst.read_reg(8'h02, rd);
         check({4'h0, rd[7:4]}, {4'h0, live});
         check({4'h0, rd[3:0]}, 8'h00);
      end
      for (int i = 0; i < 5; i++) begin
         wv = (i == 4) ? 8'h0f : 8'(1 << i);
         @(posedge clk_sys);
         #2;
         evt = wv[3:0];
         @(posedge clk_sys);
         #2;
         evt = 4'h0;
         repeat (i) @(posedge clk_sys);
         serial_host_model_inst.read_reg(8'h02, rd);
         check({4'h0, rd[3:0]}, wv);
         serial_host_model_inst.read_reg(8'h02, rd);
         check({4'h0, rd[3:0]}, 8'h00);
      end
      serial_host_model_inst.write_reg(8'h05, 8'hff, 0);
      serial_host_model_inst.read_reg(8'h05, rd);
      check(rd, 8'h00);
      $display("Test status done");
      serial_host_model_inst.write_reg(8'h01, 8'h80, 0);
      pwmIn = 1'b0;
      repeat (1990) @(posedge clk_sys);
      #2;
      check({7'h00, chipEnable}, 8'h01);
      repeat (20) @(posedge clk_sys);
      #2;
      check({7'h00, chipEnable}, 8'h00);
      check({7'h00, deviceActive}, 8'h00);
      pwmIn = 1'b1;
      loads = reloadCount;
      repeat (5) @(posedge clk_sys);
      #2;
      check({7'h00, chipEnable}, 8'h01);
      check({7'h00, deviceActive}, 8'h01);
      check(8'(reloadCount - loads), 8'h00);
      serial_host_model_inst.write_reg(8'h01, 8'h04, 0);
      trimLoadDone = 1'b0;
      serial_host_model_inst.write_reg(8'h01, 8'h05, 3);
      repeat (6) @(posedge clk_sys);
      #2;
      check(8'(reloadCount - loads), 8'h01);
      check({7'h00, deviceActive}, 8'h00);
      trimLoadDone = 1'b1;
      repeat (2) @(posedge clk_sys);
      #2;
      check(8'(reloadCount - loads), 8'h01);
      check({7'h00, deviceActive}, 8'h01);
      $display("Test power sequence done");
      stopTest();
   end
endmodule : backlight_control_status_regs_tb
